// ===== hdl/tec_thermal_event.sv
// Capability and configuration registers with the event engine behind them.
// Assumes the serial engine presents a pointer with one-cycle read and write
// strobes, and that the trip point registers live elsewhere.
`timescale 1ns/1ps
module tec_thermal_event #(
  parameter int TW = tec_pkg::TEMP_W,
  parameter int SAMPLE_PERIOD = 4096,
  parameter logic CAP_TRIPS = 1'b1,
  parameter logic CAP_HIACC = 1'b1,
  parameter logic CAP_NEG = 1'b1,
  parameter logic CAP_HV = 1'b1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [2:0] regPtr,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [15:0] regWrData,
  output logic [15:0] regRdData,
  input wire logic signed [TW-1:0] tempValue,
  input wire logic tempValid,
  input wire logic signed [TW-1:0] upperTrip,
  input wire logic signed [TW-1:0] lowerTrip,
  input wire logic signed [TW-1:0] critTrip,
  output logic sampleReq,
  output logic eventOut,
  output logic eventOe
);
  localparam logic [15:0] CAP_WORD =
    {tec_pkg::CAP_RESERVED, CAP_HV, tec_pkg::RES_CODE, CAP_NEG, CAP_HIACC, CAP_TRIPS};

  typedef struct packed {
    tec_pkg::tec_cfg_s cfg;
    logic intLatch;
    logic windowPrev;
    logic eventOe;
    logic [15:0] rdData;
  } tec_state_s;

  tec_state_s state_r;
  tec_state_s state_nxt;

  logic [tec_pkg::TRIP_CHANNELS-1:0] tripFlag;
  logic signed [TW:0] tExt;
  logic signed [TW:0] upExt;
  logic signed [TW:0] loExt;
  logic signed [TW:0] crExt;
  logic [tec_pkg::HYS_W-1:0] hysLsb;
  logic aboveWin;
  logic belowWin;
  logic critHit;
  logic windowCond;
  logic windowEdge;
  logic condNow;
  logic activeNow;
  logic cfgWrite;
  logic clearEv;
  logic lockAny;
  logic pinHigh;
  logic [15:0] cfgWord;

  assign tExt = {tempValue[TW-1], tempValue};
  assign upExt = {upperTrip[TW-1], upperTrip};
  assign loExt = {lowerTrip[TW-1], lowerTrip};
  assign crExt = {critTrip[TW-1], critTrip};

  always_comb begin
    unique case (state_r.cfg.hys)
      tec_pkg::TEC_HYS_OFF: hysLsb = tec_pkg::HYS_LSB_NONE; // R19
      tec_pkg::TEC_HYS_1P5: hysLsb = tec_pkg::HYS_LSB_1P5;
      tec_pkg::TEC_HYS_3: hysLsb = tec_pkg::HYS_LSB_3;
      tec_pkg::TEC_HYS_6: hysLsb = tec_pkg::HYS_LSB_6;
    endcase
  end

  // The lower trip runs on negated operands so one comparator serves all three.
  tec_trip_if #(.W(TW + 1)) trip[tec_pkg::TRIP_CHANNELS] ();

  genvar i;
  generate
    for (i = 0; i < tec_pkg::TRIP_CHANNELS; i++) begin : g_trip
      assign trip[i].temp = (i == tec_pkg::CH_LOWER) ? -tExt : tExt;
      assign trip[i].thresh = (i == tec_pkg::CH_UPPER) ? upExt :
                              (i == tec_pkg::CH_LOWER) ? -loExt : crExt;
      assign trip[i].hysLsb = hysLsb; // R11
      assign trip[i].sample = tempValid;
      assign trip[i].halt = state_r.cfg.shutdown; // R14
      assign tripFlag[i] = trip[i].flag;
      tec_trip_cmp #(.W(TW + 1)) u_cmp (
        .clk(clk),
        .rst(rst),
        .trip(trip[i])
      );
    end
  endgenerate

  tec_sample_tick #(.PERIOD(SAMPLE_PERIOD)) u_tick (
    .clk(clk),
    .rst(rst),
    .halt(state_r.cfg.shutdown), // R14
    .tick(sampleReq)
  );

  assign aboveWin = tripFlag[tec_pkg::CH_UPPER];
  assign belowWin = tripFlag[tec_pkg::CH_LOWER];
  assign critHit = tripFlag[tec_pkg::CH_CRIT];

  // Window conditions are masked under critical-only operation; in interrupt mode an earlier latch and the mask's own edge still assert.
  assign windowCond = (aboveWin | belowWin) & ~state_r.cfg.critOnly; // R9
  assign windowEdge = windowCond ^ state_r.windowPrev; // R8
  assign condNow = windowCond | critHit;

  // Critical events are level events in both modes.
  assign activeNow = state_r.cfg.intMode ? (state_r.intLatch | critHit) : condNow; // R10 R13

  assign cfgWrite = regWrite && (regPtr == tec_pkg::PTR_CONFIG);
  assign clearEv = cfgWrite && regWrData[tec_pkg::CFG_CLEAR] && state_r.cfg.intMode; // R22
  assign lockAny = state_r.cfg.alarmLock | state_r.cfg.critLock;
  assign pinHigh = state_r.cfg.polHigh ? activeNow : ~activeNow;

  always_comb begin
    cfgWord = tec_pkg::WORD_ZERO; // R18
    cfgWord[tec_pkg::CFG_MODE] = state_r.cfg.intMode;
    cfgWord[tec_pkg::CFG_POL] = state_r.cfg.polHigh;
    cfgWord[tec_pkg::CFG_CRIT_ONLY] = state_r.cfg.critOnly;
    cfgWord[tec_pkg::CFG_OUT_EN] = state_r.cfg.outEn;
    cfgWord[tec_pkg::CFG_STATUS] = activeNow; // R24
    cfgWord[tec_pkg::CFG_ALARM_LOCK] = state_r.cfg.alarmLock;
    cfgWord[tec_pkg::CFG_CRIT_LOCK] = state_r.cfg.critLock;
    cfgWord[tec_pkg::CFG_SHUTDOWN] = state_r.cfg.shutdown;
    cfgWord[tec_pkg::CFG_HYS_HI:tec_pkg::CFG_HYS_LO] = state_r.cfg.hys;
  end

  always_comb begin
    state_nxt = state_r;
    state_nxt.windowPrev = windowCond;
    if (regRead) begin
      unique case (regPtr)
        tec_pkg::PTR_CAPABILITY: state_nxt.rdData = CAP_WORD; // R1 R2 R3 R4 R5 R6 R7
        tec_pkg::PTR_CONFIG: state_nxt.rdData = cfgWord; // R16
        default: state_nxt.rdData = tec_pkg::WORD_ZERO;
      endcase
    end
    if (cfgWrite) begin
      if (!lockAny) begin
        state_nxt.cfg.intMode = regWrData[tec_pkg::CFG_MODE]; // R20 R23
        state_nxt.cfg.polHigh = regWrData[tec_pkg::CFG_POL];
        state_nxt.cfg.outEn = regWrData[tec_pkg::CFG_OUT_EN];
        state_nxt.cfg.hys = tec_pkg::tec_hys_e'(
          regWrData[tec_pkg::CFG_HYS_HI:tec_pkg::CFG_HYS_LO]);
      end
      if (!state_r.cfg.alarmLock) begin
        state_nxt.cfg.critOnly = regWrData[tec_pkg::CFG_CRIT_ONLY]; // R23
      end
      if (!regWrData[tec_pkg::CFG_SHUTDOWN]) begin
        state_nxt.cfg.shutdown = 1'b0; // R16
      end else if (!lockAny) begin
        state_nxt.cfg.shutdown = 1'b1; // R15
      end
      state_nxt.cfg.alarmLock = state_r.cfg.alarmLock | regWrData[tec_pkg::CFG_ALARM_LOCK]; // R21
      state_nxt.cfg.critLock = state_r.cfg.critLock | regWrData[tec_pkg::CFG_CRIT_LOCK];
    end
    // A window edge in the clearing cycle wins over the clear.
    // The latch only lives in interrupt mode, so a mode switch never shows a stale event.
    if (state_r.cfg.shutdown || !state_r.cfg.intMode) begin
      state_nxt.intLatch = 1'b0; // R14 R13
    end else if (windowEdge) begin
      state_nxt.intLatch = 1'b1; // R8
    end else if (clearEv) begin
      state_nxt.intLatch = 1'b0; // R12
    end
    state_nxt.eventOe = state_r.cfg.outEn & ~pinHigh;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_r <= '{cfg: tec_pkg::CFG_RESET, default: '0}; // R17
    end else begin
      state_r <= state_nxt;
    end
  end

  assign regRdData = state_r.rdData;
  assign eventOut = 1'b0;
  assign eventOe = state_r.eventOe;

  AST_CAP_WORD: assert property (@(posedge clk) disable iff (rst) // R1
    (regRead && regPtr == tec_pkg::PTR_CAPABILITY) |=> regRdData == CAP_WORD)
    else $error("Capability read returned a wrong word.");

  AST_CAP_RES: assert property (@(posedge clk) disable iff (rst) // R2
    (regRead && regPtr == tec_pkg::PTR_CAPABILITY) |=> regRdData[4:3] == tec_pkg::RES_CODE)
    else $error("Resolution field is not 01.");

  AST_CAP_RSVD: assert property (@(posedge clk) disable iff (rst) // R7
    (regRead && regPtr == tec_pkg::PTR_CAPABILITY) |=> regRdData[15:6] == 10'h000)
    else $error("Capability reserved bits are not zero.");

  AST_CLEAR_READS_ZERO: assert property (@(posedge clk) disable iff (rst) // R22
    (regRead && regPtr == tec_pkg::PTR_CONFIG) |=> !regRdData[tec_pkg::CFG_CLEAR])
    else $error("Clear-event bit read back as one.");

  AST_LOCK_STICKY: assert property (@(posedge clk) disable iff (rst) // R21
    (state_r.cfg.alarmLock || state_r.cfg.critLock) |=>
      ($past(state_r.cfg.alarmLock) -> state_r.cfg.alarmLock) &&
      ($past(state_r.cfg.critLock) -> state_r.cfg.critLock))
    else $error("A lock bit cleared without power-on reset.");

  AST_SHDN_REFUSED: assert property (@(posedge clk) disable iff (rst) // R15
    (lockAny && !state_r.cfg.shutdown) |=> !state_r.cfg.shutdown)
    else $error("Shutdown set while a lock bit was set.");

  AST_MODE_PROTECTED: assert property (@(posedge clk) disable iff (rst) // R20
    lockAny |=> $stable(state_r.cfg.intMode) && $stable(state_r.cfg.polHigh) &&
      $stable(state_r.cfg.outEn) && $stable(state_r.cfg.hys))
    else $error("Locked configuration bit changed.");

  AST_CRIT_NOT_CLEARED: assert property (@(posedge clk) disable iff (rst) // R10
    critHit |-> activeNow ##1 (critHit -> cfgWord[tec_pkg::CFG_STATUS]))
    else $error("Critical event not asserted.");

  AST_COMPARATOR: assert property (@(posedge clk) disable iff (rst) // R13
    (!state_r.cfg.intMode && state_r.cfg.outEn && !state_r.cfg.polHigh) |=>
      eventOe == $past(condNow))
    else $error("Comparator output differs from the trip condition.");

  AST_INT_CLEAR: assert property (@(posedge clk) disable iff (rst) // R12
    (clearEv && !windowEdge && !state_r.cfg.shutdown) |=> !state_r.intLatch)
    else $error("Clear-event did not release the interrupt.");

  AST_PIN_DRIVE: assert property (@(posedge clk) disable iff (rst) // R18
    (state_r.cfg.outEn && activeNow && !state_r.cfg.polHigh) |=> eventOe)
    else $error("Active-low event not driven low.");

  // Capability fields, one check per reported feature.
  AST_CAP_TRIPS: assert property (@(posedge clk) disable iff (rst) // R3
    (regRead && regPtr == tec_pkg::PTR_CAPABILITY) |=> regRdData[0] == CAP_TRIPS)
    else $error("Trip support bit is wrong.");

  AST_CAP_ACC: assert property (@(posedge clk) disable iff (rst) // R4
    (regRead && regPtr == tec_pkg::PTR_CAPABILITY) |=> regRdData[1] == CAP_HIACC)
    else $error("Accuracy grade bit is wrong.");

  AST_CAP_RANGE: assert property (@(posedge clk) disable iff (rst) // R5
    (regRead && regPtr == tec_pkg::PTR_CAPABILITY) |=> regRdData[2] == CAP_NEG)
    else $error("Range bit is wrong.");

  AST_CAP_HV: assert property (@(posedge clk) disable iff (rst) // R6
    (regRead && regPtr == tec_pkg::PTR_CAPABILITY) |=> regRdData[5] == CAP_HV)
    else $error("High voltage bit is wrong.");

  AST_CAP_NO_WRITE: assert property (@(posedge clk) disable iff (rst) // R1
    (regWrite && regPtr != tec_pkg::PTR_CONFIG) |=> $stable(state_r.cfg))
    else $error("A write outside the configuration word changed it.");

  // Configuration readback.
  AST_CFG_RSVD: assert property (@(posedge clk) disable iff (rst) // R18
    (regRead && regPtr == tec_pkg::PTR_CONFIG) |=> regRdData[15:11] == 5'h00)
    else $error("Configuration reserved bits are not zero.");

  AST_CFG_SHDN_READ: assert property (@(posedge clk) disable iff (rst) // R18
    (regRead && regPtr == tec_pkg::PTR_CONFIG) |=>
      regRdData[tec_pkg::CFG_SHUTDOWN] == $past(state_r.cfg.shutdown))
    else $error("Shutdown bit read back wrong.");

  AST_CFG_HYS_READ: assert property (@(posedge clk) disable iff (rst) // R19
    (regRead && regPtr == tec_pkg::PTR_CONFIG) |=>
      regRdData[tec_pkg::CFG_HYS_HI:tec_pkg::CFG_HYS_LO] == $past(state_r.cfg.hys))
    else $error("Hysteresis field read back wrong.");

  AST_CFG_LOCK_READ: assert property (@(posedge clk) disable iff (rst) // R21
    (regRead && regPtr == tec_pkg::PTR_CONFIG) |=>
      regRdData[7:6] == $past({state_r.cfg.critLock, state_r.cfg.alarmLock}))
    else $error("Lock bits read back wrong.");

  AST_RD_HOLD: assert property (@(posedge clk) disable iff (rst) // R16
    !regRead |=> $stable(regRdData))
    else $error("Read data changed without a read.");

  // Event engine.
  AST_STATUS_CRIT: assert property (@(posedge clk) disable iff (rst) // R24
    critHit |-> cfgWord[tec_pkg::CFG_STATUS])
    else $error("Status bit clear during a critical event.");

  AST_CRIT_ONLY: assert property (@(posedge clk) disable iff (rst) // R9
    (state_r.cfg.critOnly && !state_r.cfg.intMode && !critHit) |-> !activeNow)
    else $error("Window event asserted in critical-only operation.");

  AST_WIN_MASK: assert property (@(posedge clk) disable iff (rst) // R9
    state_r.cfg.critOnly |-> !windowCond)
    else $error("Window condition seen in critical-only operation.");

  AST_INT_SET: assert property (@(posedge clk) disable iff (rst) // R8
    (state_r.cfg.intMode && windowEdge && !state_r.cfg.shutdown) |=> state_r.intLatch)
    else $error("Window crossing did not raise the interrupt.");

  AST_INT_HOLD: assert property (@(posedge clk) disable iff (rst) // R12
    (state_r.cfg.intMode && state_r.intLatch && !clearEv && !state_r.cfg.shutdown) |=>
      state_r.intLatch)
    else $error("Interrupt dropped without a clear.");

  AST_SHDN_NO_EVENT: assert property (@(posedge clk) disable iff (rst) // R14
    state_r.cfg.shutdown |=> (tripFlag == '0 && !state_r.intLatch))
    else $error("Event condition held during shutdown.");

  AST_SHDN_SET: assert property (@(posedge clk) disable iff (rst) // R14
    (cfgWrite && regWrData[tec_pkg::CFG_SHUTDOWN] && !lockAny) |=> state_r.cfg.shutdown)
    else $error("Shutdown write not taken.");

  AST_SHDN_CLEAR: assert property (@(posedge clk) disable iff (rst) // R16
    (cfgWrite && !regWrData[tec_pkg::CFG_SHUTDOWN]) |=> !state_r.cfg.shutdown)
    else $error("Shutdown not cleared by a write of zero.");

  // Lock handling.
  AST_ALARM_LOCK_SET: assert property (@(posedge clk) disable iff (rst) // R21
    (cfgWrite && regWrData[tec_pkg::CFG_ALARM_LOCK]) |=> state_r.cfg.alarmLock)
    else $error("Alarm lock not set by one write.");

  AST_CRIT_LOCK_SET: assert property (@(posedge clk) disable iff (rst) // R21
    (cfgWrite && regWrData[tec_pkg::CFG_CRIT_LOCK]) |=> state_r.cfg.critLock)
    else $error("Critical lock not set by one write.");

  AST_UNLOCKED_WRITE: assert property (@(posedge clk) disable iff (rst) // R23
    (cfgWrite && !lockAny) |=>
      state_r.cfg.intMode == $past(regWrData[tec_pkg::CFG_MODE]))
    else $error("Unlocked mode bit did not update.");

  AST_CRITONLY_LOCK: assert property (@(posedge clk) disable iff (rst) // R23
    (cfgWrite && state_r.cfg.alarmLock) |=> $stable(state_r.cfg.critOnly))
    else $error("Critical-only bit changed under the alarm lock.");

  // Pin drive.
  AST_PIN_RELEASE: assert property (@(posedge clk) disable iff (rst) // R18
    !state_r.cfg.outEn |=> !eventOe)
    else $error("Event pin driven while the output is disabled.");

  AST_PIN_HIGH_POL: assert property (@(posedge clk) disable iff (rst) // R18
    (state_r.cfg.outEn && activeNow && state_r.cfg.polHigh) |=> !eventOe)
    else $error("Active-high event pulled low.");
endmodule

// ===== hdl/tec_pkg.sv
// Constants and types of the thermal event and configuration block.
// Assumes a serial engine that hands over whole 16-bit words and a converter
// that delivers signed quarter-degree temperature samples on the same clock.
// Behaviour
// [R1] Capability word is 16 bits, read only; writes to it change nothing.
// [R2] Capability bits 4:3 always read 01: 10-bit value, quarter degree steps.
// [R3] Capability bit 0 reports that alarm and critical trips are present.
// [R4] Capability bit 1 reports the accuracy grade, 1 meaning high accuracy.
// [R5] Capability bit 2 reports whether negative temperatures are reported signed.
// [R6] Capability bit 5 reads 1 by default, high voltage on lowest sub-address.
// [R7] Capability bits 15:6 always read zero.
// [R8] Alarm window events trigger when temperature enters or leaves the window.
// [R9] Critical-only operation triggers only while above the critical trip value; in interrupt mode the window latch can still assert.
// [R10] Critical events behave as comparator; clear-event never clears them.
// [R11] Every threshold applies the selected hysteresis when deciding to de-assert.
// [R12] Interrupt mode: writing clear-event de-asserts output until the next trigger.
// [R13] Comparator mode: register accesses never alter the event output.
// [R14] Shutdown halts sampling and event activity; the register port keeps working.
// [R15] Shutdown cannot be set while either lock bit is set.
// [R16] Clearing shutdown resumes sampling; all registers stay accessible meanwhile.
// [R17] Power-on reset clears shutdown and resumes continuous operation.
// [R18] Configuration word holds hysteresis, shutdown, locks, clear, status, enable, modes.
// [R19] Hysteresis codes: 00 off, 01 1.5 C, 10 3 C, 11 6 C.
// [R20] Event mode 0 is comparator, 1 interrupt; protected while a lock is set.
// [R21] A lock bit sets with one write and stays set until power-on reset.
// [R22] Clear-event reads 0 and does nothing in comparator mode.
// [R23] Locked bits ignore writes while unlocked bits of the same write update.
// [R24] Event status reads 1 exactly while an event is internally asserted.
package tec_pkg;

  localparam int TEMP_W = 11;
  localparam int TRIP_CHANNELS = 3;
  localparam int CH_UPPER = 0;
  localparam int CH_LOWER = 1;
  localparam int CH_CRIT = 2;

  localparam logic [2:0] PTR_CAPABILITY = 3'h0;
  localparam logic [2:0] PTR_CONFIG = 3'h1;

  localparam int CFG_MODE = 0;
  localparam int CFG_POL = 1;
  localparam int CFG_CRIT_ONLY = 2;
  localparam int CFG_OUT_EN = 3;
  localparam int CFG_STATUS = 4;
  localparam int CFG_CLEAR = 5;
  localparam int CFG_ALARM_LOCK = 6;
  localparam int CFG_CRIT_LOCK = 7;
  localparam int CFG_SHUTDOWN = 8;
  localparam int CFG_HYS_LO = 9;
  localparam int CFG_HYS_HI = 10;

  localparam logic [1:0] RES_CODE = 2'h1;
  localparam logic [9:0] CAP_RESERVED = 10'h000;
  localparam logic [15:0] WORD_ZERO = 16'h0000;

  localparam int HYS_W = 5;
  localparam logic [HYS_W-1:0] HYS_LSB_NONE = 5'h00;
  localparam logic [HYS_W-1:0] HYS_LSB_1P5 = 5'h06;
  localparam logic [HYS_W-1:0] HYS_LSB_3 = 5'h0c;
  localparam logic [HYS_W-1:0] HYS_LSB_6 = 5'h18;

  typedef enum logic [1:0] {
    TEC_HYS_OFF = 2'b00,
    TEC_HYS_1P5 = 2'b01,
    TEC_HYS_3 = 2'b10,
    TEC_HYS_6 = 2'b11
  } tec_hys_e;

  typedef struct packed {
    tec_hys_e hys;
    logic shutdown;
    logic critLock;
    logic alarmLock;
    logic outEn;
    logic critOnly;
    logic polHigh;
    logic intMode;
  } tec_cfg_s;

  localparam tec_cfg_s CFG_RESET = '{hys: TEC_HYS_OFF, default: 1'b0};

endpackage

// ===== hdl/tec_trip_if.sv
// Signals between the event engine and one hysteresis trip comparator.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface tec_trip_if #(
  parameter int W = 12
);
  logic signed [W-1:0] temp;
  logic signed [W-1:0] thresh;
  logic [tec_pkg::HYS_W-1:0] hysLsb;
  logic sample;
  logic halt;
  logic flag;

  modport cmp (input temp, thresh, hysLsb, sample, halt, output flag);
  modport ctl (output temp, thresh, hysLsb, sample, halt, input flag);
endinterface

// ===== hdl/tec_trip_cmp.sv
// One trip comparator: sets above its threshold, clears below threshold less hysteresis.
// Assumes the caller negates both operands to build a below-threshold trip.
`timescale 1ns/1ps
module tec_trip_cmp #(
  parameter int W = 12
) (
  input wire logic clk,
  input wire logic rst,
  tec_trip_if.cmp trip
);
  typedef struct packed {
    logic flag;
  } tec_cmp_s;

  tec_cmp_s state_r;
  tec_cmp_s state_nxt;
  logic signed [W+1:0] tExt;
  logic signed [W+1:0] thExt;
  logic signed [W+1:0] clearLim;

  assign tExt = {{2{trip.temp[W-1]}}, trip.temp};
  assign thExt = {{2{trip.thresh[W-1]}}, trip.thresh};
  assign clearLim = thExt - $signed({{(W-3){1'b0}}, trip.hysLsb});
  assign trip.flag = state_r.flag;

  always_comb begin
    state_nxt = state_r;
    if (trip.halt) begin
      state_nxt.flag = 1'b0; // R14
    end else if (trip.sample) begin
      if (tExt > thExt) begin
        state_nxt.flag = 1'b1;
      end else if (tExt < clearLim) begin
        state_nxt.flag = 1'b0; // R11
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_r <= '0;
    end else begin
      state_r <= state_nxt;
    end
  end

  AST_HYS_HOLD: assert property (@(posedge clk) disable iff (rst) // R11
    (state_r.flag && trip.sample && !trip.halt && tExt >= clearLim) |=> state_r.flag)
    else $error("Trip flag dropped inside the hysteresis band.");

  AST_HALT_CLEAR: assert property (@(posedge clk) disable iff (rst) // R14
    trip.halt |=> !state_r.flag)
    else $error("Trip flag stayed set while halted.");
endmodule

// ===== hdl/tec_sample_tick.sv
// Sampling request divider; held at zero and silent while shut down.
// Assumes one request per period is enough for the converter.
`timescale 1ns/1ps
module tec_sample_tick #(
  parameter int PERIOD = 4096
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic halt,
  output logic tick
);
  localparam int CW = $clog2(PERIOD);
  localparam logic [CW-1:0] LAST = CW'(PERIOD - 1);

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic tick;
  } tec_tick_s;

  tec_tick_s state_r;
  tec_tick_s state_nxt;

  assign tick = state_r.tick;

  always_comb begin
    state_nxt = state_r;
    state_nxt.tick = 1'b0;
    if (halt) begin
      state_nxt.cnt = '0; // R14
    end else if (state_r.cnt == LAST) begin
      state_nxt.cnt = '0;
      state_nxt.tick = 1'b1; // R16
    end else begin
      state_nxt.cnt = state_r.cnt + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_r <= '0;
    end else begin
      state_r <= state_nxt;
    end
  end

  AST_NO_TICK_HALTED: assert property (@(posedge clk) disable iff (rst) // R14
    halt |=> !state_r.tick)
    else $error("Sample request issued during shutdown.");
endmodule

// ===== test/tec_host_model.sv
// Register-port host: drives pointer, strobes and write data as the serial engine would.
// Assumes one bench process calls acc at a time.
`timescale 1ns/1ps
module tec_host_model (
  input wire logic clk,
  output logic [2:0] regPtr,
  output logic regWrite,
  output logic regRead,
  output logic [15:0] regWrData
);
  initial begin
    regPtr = 3'h0;
    regWrite = 1'b0;
    regRead = 1'b0;
    regWrData = 16'h0000;
  end

  // Data is inverted on reads so a stale write word is never mistaken for a held value.
  task automatic acc(input logic [2:0] p, input logic w, input logic [15:0] d);
    @(posedge clk);
    #1;
    regPtr = p;
    regWrite = w;
    regRead = !w;
    regWrData = w ? d : ~regWrData;
    @(posedge clk);
    #1;
    regWrite = 1'b0;
    regRead = 1'b0;
  endtask
endmodule

// ===== test/test_tec_thermal_event.sv
// Self-checking bench of the thermal event and configuration block.
// Assumes the host model drives the register port and SAMPLE_PERIOD is shortened to 8.
`timescale 1ns/1ps
module test_tec_thermal_event;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [2:0] regPtr;
  logic regWrite;
  logic regRead;
  logic [15:0] regWrData;
  logic [15:0] regRdData;
  logic signed [tec_pkg::TEMP_W-1:0] tempValue = 11'sh000;
  logic tempValid = 1'b0;
  logic sampleReq;
  logic eventOut;
  logic eventOe;
  logic rdPend = 1'b0;
  logic [15:0] expQ[$];
  logic [31:0] seed = 32'h44dc;
  logic [15:0] cfg;
  int errorCnt = 0;
  int nTests = 0;
  int ticks = 0;
  int cyc = 0;
  int hv[4] = '{0, 6, 12, 24};

  always #20 clk = ~clk;

  tec_host_model host (.clk(clk), .regPtr(regPtr), .regWrite(regWrite), .regRead(regRead),
    .regWrData(regWrData));

  tec_thermal_event #(.SAMPLE_PERIOD(8)) dut_u (.clk(clk), .rst(rst), .regPtr(regPtr),
    .regWrite(regWrite), .regRead(regRead), .regWrData(regWrData), .regRdData(regRdData),
    .tempValue(tempValue), .tempValid(tempValid), .upperTrip(11'sd40), .lowerTrip(11'sd0),
    .critTrip(11'sd200), .sampleReq(sampleReq), .eventOut(eventOut), .eventOe(eventOe));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    nTests++;
    if (seen !== exp) begin
      errorCnt++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic results;
    $display("tests=%0d mismatches=%0d", nTests, errorCnt);
    if (errorCnt == 0 && nTests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic wr(input logic [2:0] p, input logic [15:0] d);
    host.acc(p, 1'b1, d);
  endtask

  task automatic rd(input logic [2:0] p, input logic [15:0] e);
    expQ.push_back(e);
    host.acc(p, 1'b0, 16'h0000);
  endtask

  task automatic samp(input int t);
    @(posedge clk);
    #1;
    tempValue = 11'(t);
    tempValid = 1'b1;
    @(posedge clk);
    #1;
    tempValid = 1'b0;
  endtask

  task automatic ev(input logic e);
    repeat (2) @(posedge clk);
    #1;
    chk({15'h0000, eventOe}, {15'h0000, e});
    chk({15'h0000, eventOut}, 16'h0000);
  endtask

  // Read results land one cycle after the read strobe and are matched in issue order.
  always @(posedge clk) begin
    if (rdPend) begin
      chk(regRdData, expQ.pop_front());
    end
    rdPend <= regRead;
    if (sampleReq) begin
      ticks++;
    end
    cyc++;
    if (cyc == 4000) begin
      errorCnt++;
      results();
    end
  end

  initial begin
    repeat (4) @(posedge clk);
    #1;
    rst = 1'b0;
    rd(3'h0, 16'h002f);
    seed = lfsr(seed);
    wr(3'h0, seed[15:0]);
    rd(3'h0, 16'h002f);
    rd(3'h5, 16'h0000);
    rd(3'h1, 16'h0000);
    for (int i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      cfg = seed[15:0] & 16'h070f;
      wr(3'h1, cfg | 16'h0020);
      rd(3'h1, cfg);
    end
    wr(3'h1, 16'h0000);
    $display("test registers done");
    for (int h = 0; h < 4; h++) begin
      cfg = {5'h00, 2'(h), 9'h008} | {14'h0000, 1'(h), 1'b0};
      wr(3'h1, cfg);
      samp(50);
      ev(!cfg[1]);
      rd(3'h1, cfg | 16'h0010);
      samp(40 - hv[h]);
      ev(!cfg[1]);
      samp(39 - hv[h]);
      ev(cfg[1]);
    end
    wr(3'h1, 16'h0008);
    samp(50);
    wr(3'h1, 16'h0028);
    ev(1'b1);
    rd(3'h1, 16'h0018);
    samp(20);
    $display("test comparator done");
    wr(3'h1, 16'h0009);
    samp(50);
    ev(1'b1);
    wr(3'h1, 16'h0029);
    ev(1'b0);
    samp(50);
    ev(1'b0);
    samp(20);
    ev(1'b1);
    wr(3'h1, 16'h0029);
    ev(1'b0);
    samp(250);
    wr(3'h1, 16'h0029);
    ev(1'b1);
    rd(3'h1, 16'h0019);
    samp(20);
    wr(3'h1, 16'h000c);
    samp(50);
    ev(1'b0);
    samp(250);
    ev(1'b1);
    samp(20);
    ev(1'b0);
    $display("test events done");
    wr(3'h1, 16'h0108);
    repeat (2) @(posedge clk);
    ticks = 0;
    samp(250);
    ev(1'b0);
    rd(3'h1, 16'h0108);
    repeat (16) @(posedge clk);
    chk(16'(ticks), 16'h0000);
    wr(3'h1, 16'h0008);
    repeat (20) @(posedge clk);
    chk({15'h0000, ticks > 1}, 16'h0001);
    samp(20);
    $display("test shutdown done");
    wr(3'h1, 16'h0049);
    wr(3'h1, 16'h0105);
    rd(3'h1, 16'h0049);
    wr(3'h1, 16'h0080);
    rd(3'h1, 16'h00c9);
    @(posedge clk);
    #1;
    rst = 1'b1;
    repeat (2) @(posedge clk);
    #1;
    rst = 1'b0;
    rd(3'h1, 16'h0000);
    repeat (3) @(posedge clk);
    $display("test locks done");
    results();
  end
endmodule
